// ---- spoc_pkg.sv ----
// Functional notes
// - The priority 3 input depth is a 4-bit read/write field at bits 27:24 of the buffer sizing register, reset to 0010.
// - With replay_fresh_payload at 0 retransmissions are standard; at 1 they carry new payload on the old ackIDs.
// - A retransmission cap of 000 means no limit; 001 to 111 is the number of retransmissions allowed before the packet is dropped.
// - With the trace-hit message bit set, every trace match on an enabled trace comparator raises a Port Write request; with it clear, none.
// - With receive_to_transmit_loop set, serial receive data is routed through the receiver back out on the transmit side.
// - The loopback acts on the whole quad, all four lanes, not only this port's lanes.
// - Four trace comparison enables gate the four trace comparators, 0 off and 1 on.
// - Four filter comparison enables gate the four packet filters, 0 off and 1 on.
// - long_packet_receive_on at 0 refuses extended packets and at 1 accepts them.
package spoc_pkg;
	localparam logic [23:0] ADDR_BUF_SIZING = 24'hF40000;
	localparam logic [23:0] ADDR_OPS_CTRL   = 24'hF40004;
	localparam int          ADDR_W          = 24;
	localparam logic [31:0] BUF_SIZING_RST  = 32'h02220208;
	localparam logic [31:0] BUF_SIZING_MASK = 32'h0F0F0F0F;
	localparam logic [31:0] OPS_RST         = 32'h00000000;
	localparam logic [31:0] OPS_MASK        = 32'h0007FF8F;
	localparam int          PRIO0_LSB       = 0;
	localparam int          PRIO1_LSB       = 8;
	localparam int          PRIO2_LSB       = 16;
	localparam int          PRIO3_LSB       = 24;
	localparam int          DEPTH_W         = 4;
	localparam int          REPLAY_BIT      = 0;
	localparam int          CAP_LSB         = 1;
	localparam int          CAP_W           = 3;
	localparam int          PW_TRACE_BIT    = 7;
	localparam int          LOOP_BIT        = 8;
	localparam int          TRACE_EN_LSB    = 9;
	localparam int          FILTER_EN_LSB   = 13;
	localparam int          SELF_GRP_BIT    = 17;
	localparam int          LONG_RX_BIT     = 18;
	localparam int          NUM_CMP         = 4;
	localparam int          QUAD_LANES      = 4;
endpackage

// ---- spoc_retry_cap.sv ----
`timescale 1ns/100ps
module spoc_retry_cap (
	// Clock and reset
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	// Control
	input  wire logic [spoc_pkg::CAP_W-1:0] cap_i,
	// Link events for the packet in flight
	input  wire logic                      crc_err_i,
	input  wire logic                      pkt_ack_i,
	// Decisions
	output logic                           retransmit_o,
	output logic                           drop_o,
	output logic [spoc_pkg::CAP_W-1:0]     retry_cnt_o
);
	logic [spoc_pkg::CAP_W-1:0] cnt_reg;
	logic                       unlimited;
	logic                       at_cap;

	assign unlimited = (cap_i == '0);
	assign at_cap    = !unlimited && (cnt_reg >= cap_i);
	assign retransmit_o = crc_err_i && !at_cap;
	assign drop_o       = crc_err_i && at_cap;

	// Count saturates so an unlimited run cannot wrap into a false cap hit
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
		end else if (pkt_ack_i || drop_o) begin
			cnt_reg <= '0;
		end else if (crc_err_i && cnt_reg != '1) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			retry_cnt_o <= '0;
		end else begin
			retry_cnt_o <= cnt_reg;
		end
	end
endmodule

// ---- spoc_top.sv ----
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module spoc_top (
	// Clock and reset
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_i,
	// APB slave
	input  wire logic                          psel_i,
	input  wire logic                          penable_i,
	input  wire logic                          pwrite_i,
	input  wire logic [spoc_pkg::ADDR_W-1:0]   paddr_i,
	input  wire logic [31:0]                   pwdata_i,
	input  wire logic [3:0]                    pstrb_i,
	output logic [31:0]                        prdata_o,
	output logic                               pready_o,
	output logic                               pslverr_o,
	// Retransmission events (port clock domain)
	input  wire logic                          crc_err_i,
	input  wire logic                          pkt_ack_i,
	output logic                               retransmit_o,
	output logic                               reuse_ackid_o,
	output logic                               drop_o,
	// Trace and filter hits from the comparators
	input  wire logic [spoc_pkg::NUM_CMP-1:0]  trace_hit_i,
	input  wire logic [spoc_pkg::NUM_CMP-1:0]  filter_hit_i,
	output logic                               port_write_req_o,
	output logic [spoc_pkg::NUM_CMP-1:0]       trace_cmp_on_o,
	output logic [spoc_pkg::NUM_CMP-1:0]       filter_on_o,
	output logic                               pkt_filtered_o,
	// Receive packet classification
	input  wire logic                          rx_pkt_valid_i,
	input  wire logic                          rx_pkt_long_i,
	output logic                               rx_pkt_accept_o,
	output logic                               rx_pkt_refuse_o,
	// Serial lanes of the quad
	input  wire logic [spoc_pkg::QUAD_LANES-1:0] serdes_rx_i,
	input  wire logic [spoc_pkg::QUAD_LANES-1:0] phy_tx_i,
	output logic [spoc_pkg::QUAD_LANES-1:0]    phy_rx_o,
	output logic [spoc_pkg::QUAD_LANES-1:0]    serdes_tx_o,
	// Static controls and the retry count
	output logic                               self_group_delivery_on_o,
	output logic [spoc_pkg::DEPTH_W-1:0]       prio3_input_depth_o,
	output logic [spoc_pkg::CAP_W-1:0]         retry_cnt_o
);
	logic [31:0] buf_sizing_reg;
	logic [31:0] ops_ctrl_reg;
	logic [31:0] wr_mask;
	logic        acc;
	logic        wr_en;
	logic        hit_buf;
	logic        hit_ops;
	logic [31:0] rd_mux;
	logic [spoc_pkg::QUAD_LANES-1:0] rx_s1_reg;
	logic [spoc_pkg::QUAD_LANES-1:0] rx_s2_reg;
	logic        replay_fresh_payload;
	logic        receive_to_transmit_loop;
	logic        long_packet_receive_on;
	logic        pw_on_trace;
	logic        retry_raw;
	logic        drop_raw;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready_o = 1'b1;
	assign acc      = psel_i && penable_i;
	assign wr_en    = acc && pwrite_i;

	// Address decoding
	always_comb begin
		hit_buf = 1'b0;
		hit_ops = 1'b0;
		if (paddr_i == spoc_pkg::ADDR_BUF_SIZING) begin
			hit_buf = 1'b1;
		end else if (paddr_i == spoc_pkg::ADDR_OPS_CTRL) begin
			hit_ops = 1'b1;
		end
	end

	// Unmapped addresses answer with an error and read as zero
	assign pslverr_o = acc && !hit_buf && !hit_ops;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wr_mask[i*8 +: 8] = {8{pstrb_i[i]}};
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			buf_sizing_reg <= spoc_pkg::BUF_SIZING_RST;
		end else if (wr_en && hit_buf) begin
			buf_sizing_reg <= (buf_sizing_reg & ~(wr_mask & spoc_pkg::BUF_SIZING_MASK))
				| (pwdata_i & wr_mask & spoc_pkg::BUF_SIZING_MASK);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ops_ctrl_reg <= spoc_pkg::OPS_RST;
		end else if (wr_en && hit_ops) begin
			ops_ctrl_reg <= (ops_ctrl_reg & ~(wr_mask & spoc_pkg::OPS_MASK))
				| (pwdata_i & wr_mask & spoc_pkg::OPS_MASK);
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_buf) begin
			rd_mux = buf_sizing_reg;
		end else if (hit_ops) begin
			rd_mux = ops_ctrl_reg;
		end
	end

	// Read data registered during setup so it stands through the access cycle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o <= 32'h00000000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= rd_mux;
		end
	end

	// Field views
	assign replay_fresh_payload     = ops_ctrl_reg[spoc_pkg::REPLAY_BIT];
	assign pw_on_trace              = ops_ctrl_reg[spoc_pkg::PW_TRACE_BIT];
	assign receive_to_transmit_loop = ops_ctrl_reg[spoc_pkg::LOOP_BIT];
	assign long_packet_receive_on   = ops_ctrl_reg[spoc_pkg::LONG_RX_BIT];
	assign trace_cmp_on_o  = ops_ctrl_reg[spoc_pkg::TRACE_EN_LSB +: spoc_pkg::NUM_CMP];
	assign filter_on_o     = ops_ctrl_reg[spoc_pkg::FILTER_EN_LSB +: spoc_pkg::NUM_CMP];
	assign self_group_delivery_on_o = ops_ctrl_reg[spoc_pkg::SELF_GRP_BIT];
	assign prio3_input_depth_o = buf_sizing_reg[spoc_pkg::PRIO3_LSB +: spoc_pkg::DEPTH_W];

	spoc_retry_cap u_cap (
		.sys_clk_i    (sys_clk_i),
		.rst_i        (rst_i),
		.cap_i        (ops_ctrl_reg[spoc_pkg::CAP_LSB +: spoc_pkg::CAP_W]),
		.crc_err_i    (crc_err_i),
		.pkt_ack_i    (pkt_ack_i),
		.retransmit_o (retry_raw),
		.drop_o       (drop_raw),
		.retry_cnt_o  (retry_cnt_o)
	);

	// Registered decisions, one cycle after the link event
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			retransmit_o  <= 1'b0;
			drop_o        <= 1'b0;
			reuse_ackid_o <= 1'b0;
		end else begin
			retransmit_o  <= retry_raw;
			drop_o        <= drop_raw;
			reuse_ackid_o <= retry_raw && replay_fresh_payload;
		end
	end

	// Disabled comparators are masked so a stale hit never leaks through
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_write_req_o <= 1'b0;
			pkt_filtered_o   <= 1'b0;
		end else begin
			port_write_req_o <= pw_on_trace && |(trace_hit_i & trace_cmp_on_o);
			pkt_filtered_o   <= |(filter_hit_i & filter_on_o);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_pkt_accept_o <= 1'b0;
			rx_pkt_refuse_o <= 1'b0;
		end else begin
			rx_pkt_accept_o <= rx_pkt_valid_i && (!rx_pkt_long_i || long_packet_receive_on);
			rx_pkt_refuse_o <= rx_pkt_valid_i && rx_pkt_long_i && !long_packet_receive_on;
		end
	end

	// Lane inputs come from the serial front end, outside this clock
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1_reg <= '0;
			rx_s2_reg <= '0;
		end else begin
			rx_s1_reg <= serdes_rx_i;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	// Whole quad loops together: the bit cannot pick individual lanes
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phy_rx_o    <= '0;
			serdes_tx_o <= '0;
		end else begin
			phy_rx_o    <= rx_s2_reg;
			serdes_tx_o <= receive_to_transmit_loop ? rx_s2_reg : phy_tx_i;
		end
	end
endmodule

// ---- spoc_link_partner.sv ----
`timescale 1ns/100ps
module spoc_link_partner (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// Lanes
	input  wire logic [3:0] lane_tx_i,
	output logic      [3:0] lane_rx_o
);
	// One lane changes every cycle, each lane every fourth, so a stale or stuck lane cannot pass
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			lane_rx_o <= 4'h1;
		else
			lane_rx_o <= {lane_rx_o[2:0], ~lane_rx_o[3]};
	end
endmodule

// ---- spoc_monitor.sv ----
`timescale 1ns/100ps
module spoc_monitor (
	// Bus, events, classification
	input wire logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i,
	input wire logic        crc_err_i, pkt_ack_i, retransmit_o, reuse_ackid_o, drop_o,
	input wire logic        port_write_req_o, pkt_filtered_o, self_group_delivery_on_o,
	input wire logic        rx_pkt_valid_i, rx_pkt_long_i, rx_pkt_accept_o, rx_pkt_refuse_o,
	input wire logic [2:0]  retry_cnt_o,
	input wire logic [23:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	// Comparators and lanes
	input wire logic [3:0]  pstrb_i, trace_hit_i, filter_hit_i, trace_cmp_on_o, filter_on_o,
	input wire logic [3:0]  serdes_rx_i, phy_tx_i, phy_rx_o, serdes_tx_o
);
	logic [31:0] ops_reg;
	logic [2:0]  cnt_reg;
	logic [1:0]  age_reg;
	wire  [31:0] bm = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}}
		& spoc_pkg::OPS_MASK;
	wire         over = ops_reg[3:1] != 3'h0 && cnt_reg >= ops_reg[3:1];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the control word and retry count, so no read-back is needed
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ops_reg <= 32'h0;
			cnt_reg <= 3'h0;
			age_reg <= 2'h0;
		end else begin
			if (psel_i && penable_i && pwrite_i && paddr_i == spoc_pkg::ADDR_OPS_CTRL)
				ops_reg <= (ops_reg & ~bm) | (pwdata_i & bm);
			if (pkt_ack_i || (crc_err_i && over))
				cnt_reg <= 3'h0;
			else if (crc_err_i && cnt_reg != 3'h7)
				cnt_reg <= cnt_reg + 3'h1;
			if (age_reg != 2'h3)
				age_reg <= age_reg + 2'h1;
		end
	end
	sequence s_err_pass;
		crc_err_i && !pkt_ack_i && !over;
	endsequence
	sequence s_err_stop;
		crc_err_i && !pkt_ack_i && over;
	endsequence
	a_retry_pass: assert property (s_err_pass |=> retransmit_o && !drop_o)
		else $error("retransmit missing");
	a_retry_drop: assert property (s_err_stop |=> drop_o && !retransmit_o)
		else $error("drop missing");
	a_retry_quiet: assert property (!crc_err_i |=> !retransmit_o && !drop_o)
		else $error("spurious retry event");
	a_count_copy: assert property (retry_cnt_o == $past(cnt_reg))
		else $error("retry count wrong");
	a_ackid_reuse: assert property (reuse_ackid_o == (retransmit_o && $past(ops_reg[0])))
		else $error("ackid reuse wrong");
	a_trace_pw: assert property (1 |=> port_write_req_o ==
		$past(ops_reg[7] && |(trace_hit_i & ops_reg[12:9]))) else $error("port write wrong");
	a_filter_hit: assert property (1 |=> pkt_filtered_o ==
		$past(|(filter_hit_i & ops_reg[16:13]))) else $error("filter wrong");
	a_long_class: assert property (rx_pkt_valid_i |=> rx_pkt_accept_o != rx_pkt_refuse_o &&
		rx_pkt_refuse_o == $past(rx_pkt_long_i && !ops_reg[18])) else $error("class wrong");
	a_enable_bits: assert property ({self_group_delivery_on_o, filter_on_o,
		trace_cmp_on_o} == ops_reg[17:9]) else $error("enables wrong");
	a_rx_sync: assert property (age_reg == 2'h3 |-> phy_rx_o == $past(serdes_rx_i, 3))
		else $error("rx path wrong");
	a_loop_quad: assert property ($past(ops_reg[8]) |-> serdes_tx_o == phy_rx_o)
		else $error("loopback wrong");
	a_tx_direct: assert property (age_reg != 2'h0 && !$past(ops_reg[8]) |->
		serdes_tx_o == $past(phy_tx_i)) else $error("tx path wrong");
endmodule
bind spoc_top spoc_monitor u_mon (.*);

// ---- test_switch_port_operation_controls.sv ----
`timescale 1ns/100ps
module test_switch_port_operation_controls;
	logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, crc_err_i, pkt_ack_i, rd_err;
	logic        rx_pkt_valid_i, rx_pkt_long_i, retransmit_o, reuse_ackid_o, drop_o, rnd_on;
	logic        pready_o, pslverr_o, port_write_req_o, pkt_filtered_o, self_group_delivery_on_o;
	logic        rx_pkt_accept_o, rx_pkt_refuse_o;
	logic [23:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd, rnd, exp_ops, exp_sz;
	logic [31:0] bg = 32'h73C3E09C;
	logic [3:0]  pstrb_i, trace_hit_i, filter_hit_i, trace_cmp_on_o, filter_on_o;
	logic [3:0]  serdes_rx_i, phy_tx_i, phy_rx_o, serdes_tx_o, prio3_input_depth_o;
	logic [2:0]  retry_cnt_o;
	logic [15:0] hist;
	int          miscompares, n_tests, cnt, dx;
	spoc_top u_dut (.*);
	spoc_link_partner u_peer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lane_tx_i(serdes_tx_o),
		.lane_rx_o(serdes_rx_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] upd(input logic [31:0] o, d, input logic [3:0] s,
		input logic [31:0] m);
		logic [31:0] b;
		b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & m;
		return (o & ~b) | (d & b);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge sys_clk_i);
		{psel_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} <= {1'b1, w, a, d, w ? s : 4'h0};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk_i);
			if (pready_o === 1'b1)
				break;
		end
		if (n == 20) begin
			miscompares++;
			end_of_test();
		end
		{rd, rd_err} = {prdata_o, pslverr_o};
		{psel_i, penable_i} <= 2'h0;
	endtask
	// Background traffic keeps every event input busy while registers change
	always @(posedge sys_clk_i) begin
		if (rnd_on) begin
			bg <= xs(bg);
			{trace_hit_i, filter_hit_i, phy_tx_i, rx_pkt_valid_i, rx_pkt_long_i} <= bg[13:0];
			{crc_err_i, pkt_ack_i} <= {&bg[15:14], &bg[18:16]};
		end
	end
	initial begin
		{rst_i, psel_i, penable_i, pwrite_i, crc_err_i, pkt_ack_i, rnd_on} = 7'h40;
		{rx_pkt_valid_i, rx_pkt_long_i, paddr_i, pwdata_i, pstrb_i} = 62'h0;
		{trace_hit_i, filter_hit_i, phy_tx_i} = 12'h0;
		{rnd, exp_ops, exp_sz} = {32'h73C3E09C, 32'h0, spoc_pkg::BUF_SIZING_RST};
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		apb(0, spoc_pkg::ADDR_BUF_SIZING, 0, 0);
		chk("sizing", 32'h02220208, rd);
		chk("depth", 32'h2, 32'(prio3_input_depth_o));
		apb(0, spoc_pkg::ADDR_OPS_CTRL, 0, 0);
		chk("ops", 32'h0, rd);
		rnd_on <= 1'b1;
		repeat (8) begin
			rnd = xs(rnd);
			apb(1, spoc_pkg::ADDR_OPS_CTRL, rnd, rnd[3:0]);
			exp_ops = upd(exp_ops, rnd, rnd[3:0], spoc_pkg::OPS_MASK);
			apb(1, spoc_pkg::ADDR_BUF_SIZING, ~rnd, rnd[7:4]);
			exp_sz = upd(exp_sz, ~rnd, rnd[7:4], spoc_pkg::BUF_SIZING_MASK);
			apb(1, 24'hF40008, 32'hFFFFFFFF, 4'hF);
			chk("wr err", 32'h1, 32'(rd_err));
			apb(0, spoc_pkg::ADDR_OPS_CTRL, 0, 0);
			chk("ops", exp_ops, rd);
			chk("enables", 32'(exp_ops[17:9]), 32'({self_group_delivery_on_o, filter_on_o,
				trace_cmp_on_o}));
			apb(0, spoc_pkg::ADDR_BUF_SIZING, 0, 0);
			chk("sizing", exp_sz, rd);
			chk("depth", 32'(exp_sz[27:24]), 32'(prio3_input_depth_o));
			apb(0, 24'hF40008, 0, 0);
			chk("unmapped", 32'h1, 32'({rd != 32'h0, rd_err}));
		end
		rnd_on <= 1'b0;
		@(posedge sys_clk_i);
		{crc_err_i, pkt_ack_i, trace_hit_i, filter_hit_i, rx_pkt_valid_i} <= 11'h0;
		for (int c = 0; c < 8; c++) begin
			apb(1, spoc_pkg::ADDR_OPS_CTRL, 32'(c * 2 + c % 2), 4'h1);
			pkt_ack_i <= 1'b1;
			@(posedge sys_clk_i);
			pkt_ack_i <= 1'b0;
			cnt = 0;
			repeat (c == 0 ? 9 : c + 2) begin
				@(posedge sys_clk_i);
				crc_err_i <= 1'b1;
				@(posedge sys_clk_i);
				crc_err_i <= 1'b0;
				#1;
				dx = c != 0 && cnt >= c;
				// The count output trails the counter by one cycle: it still shows the prior count
				chk("count", 32'(cnt), 32'(retry_cnt_o));
				cnt = dx ? 0 : (cnt < 7 ? cnt + 1 : 7);
				chk("drop", 32'(dx), 32'(drop_o));
				chk("retx", 32'(!dx), 32'(retransmit_o));
				chk("reuse", 32'(!dx && c % 2), 32'(reuse_ackid_o));
			end
		end
		for (int i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			apb(1, spoc_pkg::ADDR_OPS_CTRL, rnd, 4'h7);
			exp_ops = upd(exp_ops, rnd, 4'h7, spoc_pkg::OPS_MASK);
			{trace_hit_i, filter_hit_i, rx_pkt_valid_i, rx_pkt_long_i} <= {rnd[31:24], 1'b1, rnd[20]};
			@(posedge sys_clk_i);
			{trace_hit_i, filter_hit_i, rx_pkt_valid_i, rx_pkt_long_i} <= 10'h0;
			#1;
			chk("pw", 32'(exp_ops[7] && |(rnd[31:28] & exp_ops[12:9])), 32'(port_write_req_o));
			chk("filt", 32'(|(rnd[27:24] & exp_ops[16:13])), 32'(pkt_filtered_o));
			chk("accept", 32'(!rnd[20] || exp_ops[18]), 32'(rx_pkt_accept_o));
			chk("refuse", 32'(rnd[20] && !exp_ops[18]), 32'(rx_pkt_refuse_o));
		end
		apb(1, spoc_pkg::ADDR_OPS_CTRL, 32'h100, 4'h2);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk_i);
			#1;
			hist = {hist[11:0], serdes_rx_i};
			if (i > 3)
				chk("loop", 32'({hist[15:12], hist[15:12]}), 32'({serdes_tx_o, phy_rx_o}));
		end
		apb(1, spoc_pkg::ADDR_OPS_CTRL, 32'h0, 4'h2);
		phy_tx_i <= 4'hA;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk("tx", 32'hA, 32'(serdes_tx_o));
		end_of_test();
	end
endmodule
